// ### hw/pcr_pkg.sv
package pcr_pkg;

    // register addresses on the management port
    localparam int PCR_ADDR_W = 5;
    localparam int PCR_DATA_W = 16;
    localparam logic [4:0] PCR_IND_OVR_ADDR = 5'h18;
    localparam logic [4:0] PCR_FUNC_CTL_ADDR = 5'h19;
    localparam logic [4:0] PCR_DIAG_ADDR = 5'h1B;

    // indicator_override fields
    localparam int PCR_OVR_W = 6;
    localparam int PCR_OVR_ACT_VAL = 0;
    localparam int PCR_OVR_LINK_VAL = 1;
    localparam int PCR_OVR_SPEED_VAL = 2;
    localparam int PCR_OVR_ACT_EN = 3;
    localparam int PCR_OVR_LINK_EN = 4;
    localparam int PCR_OVR_SPEED_EN = 5;
    localparam logic [5:0] PCR_OVR_RST = 6'h00;

    // phy_function_control fields
    localparam int PCR_FC_AUTO_X = 15;
    localparam int PCR_FC_FORCE_X = 14;
    localparam int PCR_FC_PAUSE_RX = 13;
    localparam int PCR_FC_PAUSE_TX = 12;
    localparam int PCR_FC_INJECT = 11;
    localparam int PCR_FC_LONG_SEL = 10;
    localparam int PCR_FC_RESULT = 9;
    localparam int PCR_FC_RUN = 8;
    localparam int PCR_FC_BYPASS = 7;

    // diagnostic register: error count in the upper byte
    localparam int PCR_ERR_W = 8;
    localparam int PCR_DIAG_ERR_LSB = 8;
    localparam logic [7:0] PCR_ERR_MAX = 8'hFF;

    // pulse stretch time
    localparam int PCR_CLK_MHZ = 100;
    localparam int PCR_STRETCH_MS = 50;
    localparam int PCR_STRETCH_CYC = PCR_STRETCH_MS * PCR_CLK_MHZ * 1000;
    localparam int PCR_STRETCH_W = 23;

    // self-test pattern
    localparam int PCR_PRBS_W = 15;
    localparam logic [14:0] PCR_PRBS_SEED = 15'h7FFF;
    // warm-up must refill all 15 checker stages past the loop delay
    localparam logic [4:0] PCR_WARM_LAST = 5'h1F;

    typedef enum logic [1:0] {
        PCR_ST_IDLE = 2'b00,
        PCR_ST_WARM = 2'b01,
        PCR_ST_CHECK = 2'b10
    } pcr_bist_st_t;

    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } pcr_bus_req_t;

    typedef struct packed {
        logic speed;
        logic link;
        logic act;
    } pcr_ind_t;

    // advertisement bits 11:10
    typedef struct packed {
        logic asym;
        logic pause;
    } pcr_pause_adv_t;

    // x^15+x^14+1 or x^9+x^5+1, both maximal length
    function automatic logic pcr_prbs_fb(input logic [14:0] sr,
                                         input logic long_sel);
        pcr_prbs_fb = long_sel ? (sr[14] ^ sr[13]) : (sr[8] ^ sr[4]);
    endfunction : pcr_prbs_fb

endpackage : pcr_pkg

// ### hw/pcr_prbs.sv
`timescale 1ns/1ns
`default_nettype none
module pcr_prbs
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // control
    input wire logic run,
    input wire logic long_sel,
    input wire logic inject,
    // pattern
    input wire logic rx_bit,
    output logic tx_bit,
    // status pulses
    output logic locked,
    output logic err
);
    import pcr_pkg::*;

    typedef struct packed {
        pcr_bist_st_t st;
        logic [14:0] gen;
        logic [14:0] chk;
        logic [4:0] warm;
        logic tx;
        logic locked;
        logic err;
    } pcr_prbs_state_t;

    pcr_prbs_state_t s_reg;
    pcr_prbs_state_t s_next;
    logic fb;

    always_comb
    begin
        s_next = s_reg;
        s_next.locked = 1'b0;
        s_next.err = 1'b0;
        fb = pcr_prbs_fb(s_reg.gen, long_sel);
        if (s_reg.st != PCR_ST_IDLE)
        begin
            s_next.gen = {s_reg.gen[13:0], fb};
            s_next.tx = fb ^ inject;
            // self-synchronising checker: fill from received bits
            s_next.chk = {s_reg.chk[13:0], rx_bit};
        end
        case (s_reg.st)
            PCR_ST_IDLE:
            begin
                s_next.gen = PCR_PRBS_SEED;
                s_next.chk = '0;
                s_next.warm = '0;
                s_next.tx = 1'b0;
                if (run)
                    s_next.st = PCR_ST_WARM;
            end
            PCR_ST_WARM:
            begin
                s_next.warm = s_reg.warm + 5'h01;
                if (s_reg.warm == PCR_WARM_LAST)
                begin
                    s_next.st = PCR_ST_CHECK;
                    s_next.locked = 1'b1;
                end
            end
            PCR_ST_CHECK:
                s_next.err = rx_bit != pcr_prbs_fb(s_reg.chk, long_sel);
            default:
                s_next.st = PCR_ST_IDLE;
        endcase
        if (!run)
        begin
            s_next.st = PCR_ST_IDLE;
            s_next.err = 1'b0;
            s_next.locked = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            s_reg.st <= PCR_ST_IDLE;
            s_reg.gen <= PCR_PRBS_SEED;
            s_reg.chk <= '0;
            s_reg.warm <= '0;
            s_reg.tx <= 1'b0;
            s_reg.locked <= 1'b0;
            s_reg.err <= 1'b0;
        end
        else
            s_reg <= s_next;
    end

    assign tx_bit = s_reg.tx;
    assign locked = s_reg.locked;
    assign err = s_reg.err;

endmodule : pcr_prbs
`default_nettype wire

// ### hw/pcr_regs.sv
// How it works
// - indicator override bits 15:6 ignore writes and read as zero
// - override bit 5 forces speed indicator to bit 2, else normal
// - override bit 4 forces link indicator to bit 1, else normal
// - override bit 3 forces activity indicator to bit 0, else normal
// - override reads return stored bits, not pins; all reset to zero
// - control bit 15 enables auto crossover; reset value from strap
// - control bit 14 forces crossed pairs; resets to zero
// - bit 13 reports pause receive, resolved only for full duplex
// - bit 12 reports pause transmit, resolved only for full duplex
// - writing one to bit 11 injects one error, then self clears
// - bit 10 selects 15-stage pattern, zero selects 9-stage
// - bit 8 starts or stops test; bit 9 latches pass, clears on stop
// - self-test errors are counted and readable in a diagnostic register
// - bit 7 bypasses indicator pulse stretching; resets to zero
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module pcr_regs
#(
    parameter int STRETCH_CYC = pcr_pkg::PCR_STRETCH_CYC
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // management port
    input wire pcr_pkg::pcr_bus_req_t reg_req,
    output logic [15:0] reg_rdata,
    // straps
    input wire logic strap_auto_crossover,
    // normal indications
    input wire pcr_pkg::pcr_ind_t ind_normal,
    // indicator outputs
    output logic speed_indicator_out,
    output logic link_indicator_out,
    output logic activity_collision_out,
    // negotiation results
    input wire pcr_pkg::pcr_pause_adv_t local_advertisement,
    input wire pcr_pkg::pcr_pause_adv_t partner_advertisement,
    input wire logic an_full_duplex,
    // crossover controls
    output logic auto_crossover_enable,
    output logic force_crossover,
    // pause results to the mac
    output logic pause_rx,
    output logic pause_tx,
    // self-test pattern
    output logic selftest_tx_bit,
    input wire logic selftest_rx_bit
);
    import pcr_pkg::*;

    typedef struct packed {
        logic [5:0] ind_ovr;
        logic auto_x;
        logic force_x;
        logic inject;
        logic long_sel;
        logic run;
        logic bypass;
        logic pause_rx;
        logic pause_tx;
        logic result;
        logic failed;
        logic [7:0] err_cnt;
        pcr_ind_t ind;
        logic [15:0] rdata;
    } pcr_regs_state_t;

    pcr_regs_state_t s_reg;
    pcr_regs_state_t s_next;
    pcr_ind_t ind_shown;
    logic st_locked;
    logic st_err;
    logic [1:0] pause_res;

    // 802.3 pause resolution: {rx, tx}
    function automatic logic [1:0] pcr_pause_resolve(
        input pcr_pause_adv_t loc,
        input pcr_pause_adv_t par);
        logic rx;
        logic tx;
        rx = 1'b0;
        tx = 1'b0;
        if (loc.pause && par.pause)
        begin
            rx = 1'b1;
            tx = 1'b1;
        end
        else if (!loc.pause && loc.asym && par.pause && par.asym)
            tx = 1'b1;
        else if (loc.pause && loc.asym && !par.pause && par.asym)
            rx = 1'b1;
        pcr_pause_resolve = {rx, tx};
    endfunction : pcr_pause_resolve

    // one override slice: enable picks the forced value
    function automatic logic pcr_ovr_pick(input logic en,
                                          input logic val,
                                          input logic normal);
        pcr_ovr_pick = en ? val : normal;
    endfunction : pcr_ovr_pick

    pcr_stretch #(
        .STRETCH_CYC(STRETCH_CYC)
    ) u_stretch (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .bypass(s_reg.bypass),
        .ev_in(ind_normal),
        .ev_out(ind_shown)
    );

    pcr_prbs u_prbs (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .run(s_reg.run),
        .long_sel(s_reg.long_sel),
        .inject(s_reg.inject),
        .rx_bit(selftest_rx_bit),
        .tx_bit(selftest_tx_bit),
        .locked(st_locked),
        .err(st_err)
    );

    always_comb
    begin
        s_next = s_reg;
        s_next.rdata = '0;

        // results are owned by hardware alone
        pause_res = an_full_duplex
            ? pcr_pause_resolve(local_advertisement, partner_advertisement)
            : 2'b00;
        s_next.pause_rx = pause_res[1];
        s_next.pause_tx = pause_res[0];

        // one injection per write; consumed the cycle it is seen
        if (s_reg.inject)
            s_next.inject = 1'b0;

        // test status: pass after lock, any error latches fail
        if (s_reg.run && !s_reg.failed && st_locked)
            s_next.result = 1'b1;
        if (st_err)
        begin
            s_next.result = 1'b0;
            s_next.failed = 1'b1;
            if (s_reg.err_cnt != PCR_ERR_MAX)
                s_next.err_cnt = s_reg.err_cnt + 8'h01;
        end

        if (reg_req.wr)
        begin
            case (reg_req.addr)
                PCR_IND_OVR_ADDR:
                    s_next.ind_ovr = reg_req.wdata[PCR_OVR_W-1:0];
                PCR_FUNC_CTL_ADDR:
                begin
                    s_next.auto_x = reg_req.wdata[PCR_FC_AUTO_X];
                    s_next.force_x = reg_req.wdata[PCR_FC_FORCE_X];
                    if (reg_req.wdata[PCR_FC_INJECT])
                        s_next.inject = 1'b1;
                    s_next.long_sel = reg_req.wdata[PCR_FC_LONG_SEL];
                    s_next.run = reg_req.wdata[PCR_FC_RUN];
                    s_next.bypass = reg_req.wdata[PCR_FC_BYPASS];
                    // a fresh start restarts status and count
                    if (reg_req.wdata[PCR_FC_RUN] && !s_reg.run)
                    begin
                        s_next.err_cnt = '0;
                        s_next.failed = 1'b0;
                        s_next.result = 1'b0;
                    end
                end
                default:
                    s_next.run = s_reg.run;
            endcase
        end

        // stopping clears status
        if (!s_next.run)
        begin
            s_next.result = 1'b0;
            s_next.failed = 1'b0;
        end

        if (reg_req.rd)
        begin
            case (reg_req.addr)
                PCR_IND_OVR_ADDR:
                    s_next.rdata[PCR_OVR_W-1:0] = s_reg.ind_ovr;
                PCR_FUNC_CTL_ADDR:
                begin
                    s_next.rdata[PCR_FC_AUTO_X] = s_reg.auto_x;
                    s_next.rdata[PCR_FC_FORCE_X] = s_reg.force_x;
                    s_next.rdata[PCR_FC_PAUSE_RX] = s_reg.pause_rx;
                    s_next.rdata[PCR_FC_PAUSE_TX] = s_reg.pause_tx;
                    s_next.rdata[PCR_FC_INJECT] = s_reg.inject;
                    s_next.rdata[PCR_FC_LONG_SEL] = s_reg.long_sel;
                    s_next.rdata[PCR_FC_RESULT] = s_reg.result;
                    s_next.rdata[PCR_FC_RUN] = s_reg.run;
                    s_next.rdata[PCR_FC_BYPASS] = s_reg.bypass;
                end
                PCR_DIAG_ADDR:
                    s_next.rdata[PCR_DIAG_ERR_LSB +: PCR_ERR_W] =
                        s_reg.err_cnt;
                default:
                    s_next.rdata = '0;
            endcase
        end

        // outputs registered so pins never glitch on a write
        s_next.ind.speed = pcr_ovr_pick(
            s_reg.ind_ovr[PCR_OVR_SPEED_EN],
            s_reg.ind_ovr[PCR_OVR_SPEED_VAL], ind_shown.speed);
        s_next.ind.link = pcr_ovr_pick(
            s_reg.ind_ovr[PCR_OVR_LINK_EN],
            s_reg.ind_ovr[PCR_OVR_LINK_VAL], ind_shown.link);
        s_next.ind.act = pcr_ovr_pick(
            s_reg.ind_ovr[PCR_OVR_ACT_EN],
            s_reg.ind_ovr[PCR_OVR_ACT_VAL], ind_shown.act);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            s_reg.ind_ovr <= PCR_OVR_RST;
            // strap sampled by the synchronous reset itself
            s_reg.auto_x <= strap_auto_crossover;
            s_reg.force_x <= 1'b0;
            s_reg.inject <= 1'b0;
            s_reg.long_sel <= 1'b0;
            s_reg.run <= 1'b0;
            s_reg.bypass <= 1'b0;
            s_reg.pause_rx <= 1'b0;
            s_reg.pause_tx <= 1'b0;
            s_reg.result <= 1'b0;
            s_reg.failed <= 1'b0;
            s_reg.err_cnt <= '0;
            s_reg.ind <= '0;
            s_reg.rdata <= '0;
        end
        else
            s_reg <= s_next;
    end

    // crossover engine lives elsewhere; it depends on negotiation being on
    assign auto_crossover_enable = s_reg.auto_x;
    assign force_crossover = s_reg.force_x;
    assign pause_rx = s_reg.pause_rx;
    assign pause_tx = s_reg.pause_tx;
    assign speed_indicator_out = s_reg.ind.speed;
    assign link_indicator_out = s_reg.ind.link;
    assign activity_collision_out = s_reg.ind.act;
    assign reg_rdata = s_reg.rdata;

endmodule : pcr_regs
`default_nettype wire

// ### hw/pcr_stretch.sv
`timescale 1ns/1ns
`default_nettype none
module pcr_stretch
#(
    parameter int STRETCH_CYC = pcr_pkg::PCR_STRETCH_CYC
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // events
    input wire logic bypass,
    input wire pcr_pkg::pcr_ind_t ev_in,
    output pcr_pkg::pcr_ind_t ev_out
);
    import pcr_pkg::*;

    typedef struct packed {
        logic [2:0][PCR_STRETCH_W-1:0] cnt;
        logic [2:0] out;
    } pcr_str_state_t;

    pcr_str_state_t s_reg;
    pcr_str_state_t s_next;
    logic [2:0] ev;

    always_comb
    begin
        s_next = s_reg;
        ev = ev_in;
        for (int i = 0; i < 3; i++)
        begin
            if (ev[i])
                s_next.cnt[i] = PCR_STRETCH_W'(STRETCH_CYC - 1);
            else if (s_reg.cnt[i] != '0)
                s_next.cnt[i] = s_reg.cnt[i] - PCR_STRETCH_W'(1);
            // bypass follows the raw event with no hold
            s_next.out[i] = bypass ? ev[i]
                : (ev[i] | (s_reg.cnt[i] != '0));
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            s_reg.cnt <= '0;
            s_reg.out <= '0;
        end
        else
            s_reg <= s_next;
    end

    assign ev_out = s_reg.out;

endmodule : pcr_stretch
`default_nettype wire

// ### sim/pcr_loop.sv
`timescale 1ns/1ns
`default_nettype none
module pcr_loop
(
    // clock
    input wire logic clk_sys,
    // pattern loop
    input wire logic tx_bit,
    input wire logic flip,
    output logic rx_bit
);
    // one cycle of line delay; corrupts a bit only on command
    always_ff @(posedge clk_sys)
    begin
        rx_bit <= tx_bit ^ flip;
    end
endmodule : pcr_loop
`default_nettype wire

// ### sim/pcr_regs_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module pcr_regs_asserts
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // management port
    input wire pcr_pkg::pcr_bus_req_t reg_req,
    input wire logic [15:0] reg_rdata,
    // inputs
    input wire logic strap_auto_crossover,
    input wire pcr_pkg::pcr_pause_adv_t local_advertisement,
    input wire pcr_pkg::pcr_pause_adv_t partner_advertisement,
    input wire logic an_full_duplex,
    // outputs
    input wire logic speed_indicator_out,
    input wire logic link_indicator_out,
    input wire logic activity_collision_out,
    input wire logic auto_crossover_enable,
    input wire logic force_crossover,
    input wire logic pause_rx,
    input wire logic pause_tx
);
    import pcr_pkg::*;
    logic ovr_wr;
    logic ctl_wr;
    logic ovr_rd;
    logic ctl_rd;
    logic [15:0] d;
    assign ovr_wr = reg_req.wr && reg_req.addr == PCR_IND_OVR_ADDR;
    assign ctl_wr = reg_req.wr && reg_req.addr == PCR_FUNC_CTL_ADDR;
    assign ovr_rd = reg_req.rd && reg_req.addr == PCR_IND_OVR_ADDR;
    assign ctl_rd = reg_req.rd && reg_req.addr == PCR_FUNC_CTL_ADDR;
    assign d = reg_req.wdata;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_ovr_back;
        ovr_wr ##1 !reg_req.wr ##1 ovr_rd;
    endsequence
    sequence s_inj_back;
        ctl_wr && d[PCR_FC_INJECT] ##1 !reg_req.wr ##1 ctl_rd;
    endsequence
    sequence s_stop_back;
        ctl_wr && !d[PCR_FC_RUN] ##1 !reg_req.wr ##1 ctl_rd;
    endsequence
    property p_rsv;
        ovr_rd |=> reg_rdata[15:6] == 10'h000;
    endproperty
    property p_back;
        s_ovr_back |=> reg_rdata[5:0] == $past(d[5:0], 3);
    endproperty
    property p_spd;
        ovr_wr && d[5] |-> ##2 speed_indicator_out == $past(d[2], 2);
    endproperty
    property p_lnk;
        ovr_wr && d[4] |-> ##2 link_indicator_out == $past(d[1], 2);
    endproperty
    property p_act;
        ovr_wr && d[3] |-> ##2 activity_collision_out == $past(d[0], 2);
    endproperty
    property p_strap;
        $rose(rstn) |-> auto_crossover_enable == $past(strap_auto_crossover);
    endproperty
    property p_xover;
        ctl_wr |=> force_crossover == $past(d[14]);
    endproperty
    property p_half;
        !an_full_duplex |=> !pause_rx && !pause_tx;
    endproperty
    property p_sym;
        an_full_duplex && local_advertisement.pause
            && partner_advertisement.pause |=> pause_rx && pause_tx;
    endproperty
    property p_inj;
        s_inj_back |=> !reg_rdata[PCR_FC_INJECT];
    endproperty
    property p_stop;
        s_stop_back |=> !reg_rdata[PCR_FC_RESULT];
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved override bits not zero");
    a_back: assert property (p_back)
        else $error("override readback differs");
    a_spd: assert property (p_spd)
        else $error("speed indicator not forced");
    a_lnk: assert property (p_lnk)
        else $error("link indicator not forced");
    a_act: assert property (p_act)
        else $error("activity indicator not forced");
    a_strap: assert property (p_strap)
        else $error("crossover enable not from strap");
    a_xover: assert property (p_xover)
        else $error("force crossover not written");
    a_half: assert property (p_half)
        else $error("pause set in half duplex");
    a_sym: assert property (p_sym)
        else $error("symmetric pause not resolved");
    a_inj: assert property (p_inj)
        else $error("inject bit not self cleared");
    a_stop: assert property (p_stop)
        else $error("result not cleared on stop");
endmodule : pcr_regs_asserts
bind pcr_regs pcr_regs_asserts u_chk
(
    .clk_sys(clk_sys), .rstn(rstn), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .strap_auto_crossover(strap_auto_crossover),
    .local_advertisement(local_advertisement),
    .partner_advertisement(partner_advertisement),
    .an_full_duplex(an_full_duplex),
    .speed_indicator_out(speed_indicator_out),
    .link_indicator_out(link_indicator_out),
    .activity_collision_out(activity_collision_out),
    .auto_crossover_enable(auto_crossover_enable),
    .force_crossover(force_crossover), .pause_rx(pause_rx),
    .pause_tx(pause_tx)
);
`default_nettype wire

// ### sim/pcr_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pcr_regs_tb;
    import pcr_pkg::*;
    localparam int STR = 8;
    logic clk_sys;
    logic rstn;
    pcr_bus_req_t req;
    logic [15:0] rdata;
    logic strap;
    pcr_ind_t ind_in;
    wire logic [2:0] pins;
    pcr_pause_adv_t loc_adv;
    pcr_pause_adv_t par_adv;
    logic fd;
    logic acx;
    logic fcx;
    logic p_rx;
    logic p_tx;
    logic tx_bit;
    logic rx_bit;
    logic flip;
    logic [15:0] ov;
    logic [15:0] got;
    int n_mismatch;
    int cmp_count;
    int cyc;
    // {loc asym, loc pause, par asym, par pause, duplex, rx, tx}
    logic [6:0] ptab [5] = '{7'h2F, 7'h5D, 7'h76, 7'h28, 7'h7F};

    pcr_regs #(.STRETCH_CYC(STR)) DUT
    (
        .clk_sys(clk_sys), .rstn(rstn), .reg_req(req), .reg_rdata(rdata),
        .strap_auto_crossover(strap), .ind_normal(ind_in),
        .speed_indicator_out(pins[2]), .link_indicator_out(pins[1]),
        .activity_collision_out(pins[0]), .local_advertisement(loc_adv),
        .partner_advertisement(par_adv), .an_full_duplex(fd),
        .auto_crossover_enable(acx), .force_crossover(fcx),
        .pause_rx(p_rx), .pause_tx(p_tx), .selftest_tx_bit(tx_bit),
        .selftest_rx_bit(rx_bit)
    );
    pcr_loop u_loop
    (
        .clk_sys(clk_sys), .tx_bit(tx_bit), .flip(flip), .rx_bit(rx_bit)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic test_done;
        $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [15:0] m,
                      input logic [15:0] e);
        @(posedge clk_sys);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1;
        got = rdata;
        chk(rdata & m, e);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    // generous ceiling, the sequence needs well under a thousand cycles
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    initial
    begin
        req = '0;
        rstn = 1'b0;
        strap = 1'b1;
        ind_in = '0;
        loc_adv = '0;
        par_adv = '0;
        fd = 1'b0;
        flip = 1'b0;
        n_mismatch = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(PCR_IND_OVR_ADDR, 16'hFFFF, 16'h0000);
        rd(PCR_FUNC_CTL_ADDR, 16'hFFFF, 16'h8000);
        chk({13'h0, pins}, 16'h0000);
        wr(5'h05, 16'hFFFF);
        rd(5'h05, 16'hFFFF, 16'h0000);
        rd(PCR_IND_OVR_ADDR, 16'hFFFF, 16'h0000);
        $display("test reset done");
        wr(PCR_IND_OVR_ADDR, 16'hFFFF);
        rd(PCR_IND_OVR_ADDR, 16'hFFFF, 16'h003F);
        wr(PCR_FUNC_CTL_ADDR, 16'h0080);
        for (int k = 0; k < 6; k++)
        begin
            ind_in <= (k < 3) ? 3'b000 : 3'b111;
            ov = 16'h0008 << (k % 3) | ((k < 3) ? 16'h0007 : 16'h0000);
            wr(PCR_IND_OVR_ADDR, ov);
            tick(3);
            chk({13'h0, pins}, (k < 3) ? 16'h0001 << (k % 3)
                : 16'h0007 ^ (16'h0001 << (k % 3)));
            rd(PCR_IND_OVR_ADDR, 16'hFFFF, ov);
        end
        $display("test indicators done");
        wr(PCR_IND_OVR_ADDR, 16'h0000);
        ind_in <= 3'b000;
        for (int b = 0; b < 2; b++)
        begin
            wr(PCR_FUNC_CTL_ADDR, b ? 16'h0080 : 16'h0000);
            tick(STR + 4);
            ind_in <= 3'b001;
            @(posedge clk_sys);
            ind_in <= 3'b000;
            tick(5);
            chk({15'h0, pins[0]}, b ? 16'h0000 : 16'h0001);
            tick(STR);
            chk({15'h0, pins[0]}, 16'h0000);
        end
        $display("test stretch done");
        for (int t = 0; t < 5; t++)
        begin
            {loc_adv, par_adv, fd} <= ptab[t][6:2];
            tick(2);
            chk({14'h0, p_rx, p_tx}, {14'h0, ptab[t][1:0]});
            wr(PCR_FUNC_CTL_ADDR, 16'h3000);
            rd(PCR_FUNC_CTL_ADDR, 16'h3000,
               {2'b00, ptab[t][1:0], 12'h000});
        end
        $display("test pause done");
        wr(PCR_FUNC_CTL_ADDR, 16'hFEFF);
        rd(PCR_FUNC_CTL_ADDR, 16'hCFFF, 16'hC480);
        chk({14'h0, acx, fcx}, 16'h0003);
        wr(PCR_FUNC_CTL_ADDR, 16'h0000);
        rd(PCR_FUNC_CTL_ADDR, 16'hCF80, 16'h0000);
        chk({14'h0, acx, fcx}, 16'h0000);
        $display("test control done");
        for (int s = 0; s < 2; s++)
        begin
            wr(PCR_FUNC_CTL_ADDR, {5'h0, s[0], 10'h000});
            wr(PCR_FUNC_CTL_ADDR, {5'h0, s[0], 10'h100});
            tick(40);
            rd(PCR_FUNC_CTL_ADDR, 16'h0700, {5'h0, s[0], 10'h300});
            rd(PCR_DIAG_ADDR, 16'hFF00, 16'h0000);
            if (s == 0)
                wr(PCR_FUNC_CTL_ADDR, 16'h0900);
            else
            begin
                @(posedge clk_sys);
                flip <= 1'b1;
                @(posedge clk_sys);
                flip <= 1'b0;
            end
            tick(40);
            rd(PCR_FUNC_CTL_ADDR, 16'h0B00, 16'h0100);
            rd(PCR_DIAG_ADDR, 16'hFC00, 16'h0000);
            chk({15'h0, got[15:8] != 8'h00}, 16'h0001);
            wr(PCR_FUNC_CTL_ADDR, {5'h0, s[0], 10'h000});
            rd(PCR_FUNC_CTL_ADDR, 16'h0300, 16'h0000);
        end
        $display("test selftest done");
        // second reset with the strap low: reset must reload, not hold
        wr(PCR_FUNC_CTL_ADDR, 16'hC000);
        wr(PCR_IND_OVR_ADDR, 16'h003F);
        strap <= 1'b0;
        rstn <= 1'b0;
        tick(2);
        rstn <= 1'b1;
        rd(PCR_FUNC_CTL_ADDR, 16'hCF80, 16'h0000);
        rd(PCR_IND_OVR_ADDR, 16'hFFFF, 16'h0000);
        chk({14'h0, acx, fcx}, 16'h0000);
        chk({13'h0, pins}, 16'h0000);
        $display("test second reset done");
        test_done();
    end
endmodule : pcr_regs_tb
`default_nettype wire
